// *** testbench/lf_osc_model.sv ***
// slow oscillator of the clock system
// assumes sys_clk is far faster than it
`timescale 1ns/1ps
module lf_osc_model
#(
  parameter int HALF = 8
)
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic oscEnable,
  output logic      lowFreqOscillator
);
  int phase;
  always_ff @(posedge sys_clk)
  begin
    if (rst || !oscEnable) // stands low when stopped
    begin
      phase <= 0;
      lowFreqOscillator <= 1'b0;
    end
    else
    begin
      phase <= (phase == HALF - 1) ? 0 : phase + 1;
      if (phase == HALF - 1)
        lowFreqOscillator <= !lowFreqOscillator;
    end
  end
endmodule // lf_osc_model

// *** testbench/watchdog_timer_control_properties.sv ***
// port checker of the watchdog timer block
// assumes it is bound onto every watchdog_timer_control
`timescale 1ns/1ps
module watchdog_timer_control_properties
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // bus
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // configuration and events
  input wire logic [1:0]  watchdogModeConfig,
  input wire logic        clearInstruction,
  input wire logic        oscFail,
  // results
  input wire logic        watchdogReset,
  input wire logic        wakeRequest,
  input wire logic        expiryFlagN,
  input wire logic        sleepFlagN,
  input wire logic        watchdogResetFlag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_wait; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_bite; watchdogReset || wakeRequest; endsequence
  property p_answer; s_wait |=> !avs_waitrequest; endproperty
  property p_rdzero; avs_read && !avs_waitrequest |-> avs_readdata[31:6] == 26'h0; endproperty
  property p_clrblk; clearInstruction |=> !watchdogReset && !wakeRequest; endproperty
  property p_clrflags; clearInstruction |=> expiryFlagN && sleepFlagN; endproperty
  property p_failblk; oscFail |=> !watchdogReset; endproperty
  property p_off;
    watchdogModeConfig == 2'h0 && $past(watchdogModeConfig) == 2'h0 |-> not s_bite;
  endproperty
  property p_wake; wakeRequest |-> !watchdogReset && !sleepFlagN; endproperty
  property p_flag; s_bite |-> watchdogResetFlag && !expiryFlagN; endproperty
  property p_pulse; watchdogReset |=> !watchdogReset; endproperty
  property p_fell; $fell(expiryFlagN) |-> s_bite; endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");
  a_rdzero: assert property (p_rdzero) else $error("upper bits set");
  a_clrblk: assert property (p_clrblk) else $error("expiry after clear");
  a_clrflags: assert property (p_clrflags) else $error("flags kept");
  a_failblk: assert property (p_failblk) else $error("expiry on fail");
  a_off: assert property (p_off) else $error("expiry while off");
  a_wake: assert property (p_wake) else $error("bad wake");
  a_flag: assert property (p_flag) else $error("flag not set");
  a_pulse: assert property (p_pulse) else $error("long reset pulse");
  a_fell: assert property (p_fell) else $error("flag without expiry");
endmodule // watchdog_timer_control_properties

bind watchdog_timer_control watchdog_timer_control_properties chk (.sys_clk, .rst,
  .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .watchdogModeConfig,
  .clearInstruction, .oscFail, .watchdogReset, .wakeRequest, .expiryFlagN,
  .sleepFlagN, .watchdogResetFlag);

// *** testbench/watchdog_timer_control_test.sv ***
// self-checking bench of the watchdog timer block
// assumes oscillator model and checker are compiled with it
`timescale 1ns/1ps
module watchdog_timer_control_test;
  logic        sys_clk, rst, powerOnReset, avs_read, avs_write, oscEnable;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rdValue;
  logic        avs_waitrequest, lowFreqOscillator, prevOsc, crystal;
  logic [1:0]  mode;
  logic [4:0]  evs;
  logic        watchdogReset, wakeRequest, expiryFlagN, sleepFlagN, watchdogResetFlag;
  int          mismatches, cmp_count, cycles;
  watchdog_timer_control uut (.sys_clk, .rst, .powerOnReset, .avs_address, .avs_read,
    .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .lowFreqOscillator, .watchdogModeConfig(mode), .clearInstruction(evs[0]),
    .sleepEnter(evs[1]), .sleepExit(evs[2]), .oscFail(evs[3]),
    .startupHoldTimer(evs[4]), .crystalClock(crystal), .watchdogReset, .wakeRequest,
    .expiryFlagN, .sleepFlagN, .watchdogResetFlag);
  lf_osc_model #(.HALF(8)) osc (.sys_clk, .rst, .oscEnable, .lowFreqOscillator);
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task report_and_stop;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 40000)
    begin
      mismatches++;
      report_and_stop;
    end
  end
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rdValue = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task pulse(input int b);
    @(posedge sys_clk);
    evs[b] <= 1'b1;
    @(posedge sys_clk);
    evs[b] <= 1'b0;
  endtask
  // ticks from clear (or from event ev) until a bite; 0 means none
  task run(input logic [4:0] code, input logic [1:0] md, input logic en, input logic sl,
           input int ev, input int exp);
    int ticks;
    bit seen, done;
    oscEnable <= 1'b0;
    mode <= md;
    bus(1'b1, 4'h0, {26'h0, code, en});
    pulse(0);
    if (sl)
      pulse(1);
    oscEnable <= 1'b1;
    ticks = 0;
    seen = 0;
    done = (ev < 0);
    prevOsc = 1'b0;
    while (!seen && ticks < 70)
    begin
      @(posedge sys_clk);
      if (lowFreqOscillator && !prevOsc)
        ticks++;
      if (!done && ticks == 10 && !lowFreqOscillator && prevOsc)
      begin
        pulse(ev);
        ticks = 0;
        done = 1;
      end
      prevOsc = lowFreqOscillator;
      seen = (watchdogReset === 1'b1) || (wakeRequest === 1'b1);
      if (seen)
        check("wake kind", {31'h0, wakeRequest}, {31'h0, sl && (ev != 2)});
    end
    check("ticks", seen ? 32'(ticks) : 32'h0, 32'(exp));
    oscEnable <= 1'b0;
    if (sl && !seen)
      pulse(2);
  endtask
  initial
  begin
    {rst, powerOnReset, mode} = 4'hf;
    {avs_read, avs_write, avs_address, avs_writedata, evs, oscEnable, crystal} = '0;
    avs_byteenable = 4'hf;
    {mismatches, cmp_count, cycles} = '0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    bus(1'b0, 4'h0, 32'h0);
    check("ctrl reset", rdValue, 32'h16);
    bus(1'b1, 4'h0, 32'hff);
    bus(1'b0, 4'h0, 32'h0);
    check("ctrl bits", rdValue, 32'h3f);
    bus(1'b1, 4'h8, 32'hff);
    bus(1'b0, 4'h8, 32'h0);
    check("unmapped", rdValue, 32'h0);
    run(5'h00, 2'h3, 1'b0, 1'b0, -1, 32);
    bus(1'b0, 4'h4, 32'h0);
    check("awake flags", rdValue & 32'h7, 32'h5);
    run(5'h01, 2'h3, 1'b0, 1'b0, -1, 64);
    run(5'h13, 2'h3, 1'b0, 1'b0, -1, 32);
    run(5'h1f, 2'h3, 1'b0, 1'b0, -1, 32);
    run(5'h00, 2'h3, 1'b0, 1'b0, 0, 32);
    run(5'h00, 2'h3, 1'b0, 1'b0, 3, 32);
    run(5'h00, 2'h3, 1'b0, 1'b0, 4, 32);
    bus(1'b1, 4'h4, 32'h1);
    bus(1'b0, 4'h4, 32'h0);
    check("flag clear", rdValue & 32'h1, 32'h0);
    run(5'h00, 2'h3, 1'b0, 1'b1, -1, 32);
    bus(1'b0, 4'h4, 32'h0);
    check("sleep flags", rdValue & 32'h7, 32'h1);
    run(5'h00, 2'h3, 1'b0, 1'b1, 2, 32);
    crystal <= 1'b1;
    run(5'h00, 2'h3, 1'b0, 1'b1, 2, 32);
    crystal <= 1'b0;
    run(5'h00, 2'h2, 1'b0, 1'b0, -1, 32);
    run(5'h00, 2'h2, 1'b0, 1'b1, -1, 0);
    run(5'h00, 2'h0, 1'b1, 1'b0, -1, 0);
    run(5'h00, 2'h1, 1'b0, 1'b0, -1, 0);
    run(5'h00, 2'h1, 1'b1, 1'b0, -1, 32);
    run(5'h00, 2'h1, 1'b1, 1'b1, -1, 32);
    check("flag pins", {29'h0, sleepFlagN, expiryFlagN, watchdogResetFlag}, 32'h1);
    // warm reset keeps the status flags
    @(posedge sys_clk);
    rst <= 1'b1;
    powerOnReset <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    bus(1'b0, 4'h0, 32'h0);
    check("ctrl warm reset", rdValue, 32'h16);
    bus(1'b0, 4'h4, 32'h0);
    check("flags kept", rdValue & 32'h1f, 32'h1);
    avs_byteenable <= 4'he;
    bus(1'b1, 4'h0, 32'h3f);
    avs_byteenable <= 4'hf;
    bus(1'b0, 4'h0, 32'h0);
    check("byte gated", rdValue, 32'h16);
    bus(1'b1, 4'h0, 32'h01);
    pulse(1);
    bus(1'b0, 4'h4, 32'h0);
    check("asleep status", rdValue & 32'h1f, 32'h1b);
    pulse(2);
    // power-on reset clears the status flags
    @(posedge sys_clk);
    rst <= 1'b1;
    powerOnReset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    bus(1'b0, 4'h4, 32'h0);
    check("power-on flags", rdValue & 32'h1f, 32'h6);
    report_and_stop;
  end
endmodule // watchdog_timer_control_test

// *** verilog/watchdog_params.svh ***
// constants of the watchdog timer block: offsets, fields, reset values
// assumes an Avalon-MM slave with a 4-bit byte address
`ifndef WATCHDOG_PARAMS_SVH
`define WATCHDOG_PARAMS_SVH

// register byte offsets
`define WD_CTRL_OFFSET      4'h0
`define WD_STATUS_OFFSET    4'h4

// control register fields
`define WD_SOFT_EN_BIT      0
`define WD_PERIOD_LSB       1
`define WD_PERIOD_MSB       5
`define WD_CTRL_WIDTH       8

// status register fields
`define WD_STAT_RESET_FLAG  0
`define WD_STAT_EXPIRY_N    1
`define WD_STAT_SLEEP_N     2
`define WD_STAT_ACTIVE      3
`define WD_STAT_ASLEEP      4

// reset values
`define WD_PERIOD_RESET     5'h0b
`define WD_SOFT_EN_RESET    1'b0

// period coding
`define WD_PERIOD_MAX       5'h12
`define WD_PERIOD_MIN       5'h00
`define WD_MIN_SHIFT        5'h05
`define WD_COUNT_WIDTH      23

// configuration mode codes
`define WD_MODE_OFF         2'h0
`define WD_MODE_SOFT        2'h1
`define WD_MODE_AWAKE       2'h2
`define WD_MODE_ALWAYS      2'h3

`endif

// *** verilog/watchdog_pkg.sv ***
// types of the watchdog timer block
// assumes watchdog_params.svh is on the include path
package watchdog_pkg;
  `include "watchdog_params.svh"

  typedef enum logic [1:0]
  {
    AWAKE    = 2'h0,
    ASLEEP   = 2'h1,
    OST_HOLD = 2'h3
  } sleep_state_t;

  typedef struct packed
  {
    logic [4:0]                 periodSelect;
    logic                       softEnable;
    sleep_state_t               sleepState;
    logic [2:0]                 lfSync;
    logic                       lfLevel;
    logic [`WD_COUNT_WIDTH-1:0] count;
    logic                       expiryFlagN;
    logic                       sleepFlagN;
    logic                       resetFlag;
    logic                       wdReset;
    logic                       wakeReq;
    logic                       ack;
    logic [31:0]                readData;
  } state_t;
endpackage

// *** verilog/watchdog_timer_control.sv ***
// watchdog timer: prescaled count of the low-frequency oscillator, reset or wake on expiry
// assumes core, clock system and reset logic run on sys_clk; oscillator arrives as a pin
//
// Behaviour
// - period select code n gives prescale 2^(n+5), codes 0 to 18.
// - after reset period select is 01011 and soft enable reads zero.
// - reserved period codes 10011 to 11111 act as minimum 1:32 interval.
// - count clears on reset, clear, sleep entry/exit, osc fail, disable, startup timer.
// - sleep entry clears count; enabled watchdog resumes counting from zero.
// - sleep exit clears count; crystal clocks hold it clear until startup timer ends.
// - expiry in sleep wakes the device, no reset, and updates both status flags.
// - a watchdog reset flag records every watchdog expiry for software.
// - oscillator divider changes leave the count untouched.
// - mode 01 uses soft enable; modes 00 and 1x ignore it.
// - time base is the low-frequency oscillator, not the system clock.
// - control bits 7-6 read zero, period at bits 5-1, enable at bit 0.
// - expiry while awake issues a device reset.
// - mode 11 always on, 10 awake only, 01 software, 00 off.
`timescale 1ns/1ps

module watchdog_timer_control
  import watchdog_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        powerOnReset,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // oscillator pin
  input  wire logic        lowFreqOscillator,
  // configuration word
  input  wire logic [1:0]  watchdogModeConfig,
  // processor core events
  input  wire logic        clearInstruction,
  input  wire logic        sleepEnter,
  input  wire logic        sleepExit,
  // clock system
  input  wire logic        oscFail,
  input  wire logic        startupHoldTimer,
  input  wire logic        crystalClock,
  // reset and status logic
  output logic             watchdogReset,
  output logic             wakeRequest,
  output logic             expiryFlagN,
  output logic             sleepFlagN,
  output logic             watchdogResetFlag
);
  import watchdog_pkg::*;

  state_t s;
  state_t next_s;

  // expiry limit of the prescaled count
  function automatic logic [`WD_COUNT_WIDTH-1:0] periodLimit(input logic [4:0] code);
    logic [4:0] shift;
    shift = `WD_MIN_SHIFT;
    if (code <= `WD_PERIOD_MAX)
    begin
      shift = code + `WD_MIN_SHIFT;
    end
    else
    begin
      shift = `WD_PERIOD_MIN + `WD_MIN_SHIFT;
    end
    periodLimit = (`WD_COUNT_WIDTH'(1) << shift) - `WD_COUNT_WIDTH'(1);
  endfunction

  // register read decode
  function automatic logic [31:0] readReg(input logic [3:0] addr, input state_t st,
                                          input logic act);
    readReg = 32'h0;
    if (addr == `WD_CTRL_OFFSET)
    begin
      readReg[`WD_PERIOD_MSB:`WD_PERIOD_LSB] = st.periodSelect;
      readReg[`WD_SOFT_EN_BIT]               = st.softEnable;
    end
    else if (addr == `WD_STATUS_OFFSET)
    begin
      readReg[`WD_STAT_RESET_FLAG] = st.resetFlag;
      readReg[`WD_STAT_EXPIRY_N]   = st.expiryFlagN;
      readReg[`WD_STAT_SLEEP_N]    = st.sleepFlagN;
      readReg[`WD_STAT_ACTIVE]     = act;
      readReg[`WD_STAT_ASLEEP]     = (st.sleepState == ASLEEP);
    end
  endfunction

  logic                       busReq;
  logic                       writeTaken;
  logic                       asleep;
  logic                       active;
  logic                       tick;
  logic                       clearCount;
  logic                       expire;
  logic [`WD_COUNT_WIDTH-1:0] limit;

  always_comb
  begin
    next_s = s;
    next_s.wdReset = 1'b0;
    next_s.wakeReq = 1'b0;

    // bus handshake: one wait cycle per access
    busReq     = avs_read | avs_write;
    writeTaken = avs_write & s.ack;
    next_s.ack = busReq & ~s.ack;

    asleep = (s.sleepState == ASLEEP);

    // operating mode
    case (watchdogModeConfig)
      `WD_MODE_ALWAYS: active = 1'b1;
      `WD_MODE_AWAKE:  active = ~asleep;
      `WD_MODE_SOFT:   active = s.softEnable;
      default:         active = 1'b0;
    endcase

    // oscillator pin, three flops, filtered level
    next_s.lfSync = {s.lfSync[1:0], lowFreqOscillator};
    if (s.lfSync[1] == s.lfSync[2])
    begin
      next_s.lfLevel = s.lfSync[2];
    end
    tick = next_s.lfLevel & ~s.lfLevel;

    // clear conditions; divider settings are not among them
    clearCount = clearInstruction | sleepEnter | sleepExit | oscFail
                 | ~active | startupHoldTimer
                 | (s.sleepState == OST_HOLD);

    limit  = periodLimit(s.periodSelect);
    expire = active & ~clearCount & tick & (s.count == limit);

    // prescaled count; clears win over ticks in the same cycle
    if (clearCount | expire)
    begin
      next_s.count = '0;
    end
    else if (tick)
    begin
      next_s.count = s.count + `WD_COUNT_WIDTH'(1);
    end

    // register read data, captured in the wait cycle
    if (busReq & ~s.ack)
    begin
      next_s.readData = readReg(avs_address, s, active);
    end

    // control register write
    if (writeTaken && avs_address == `WD_CTRL_OFFSET && avs_byteenable[0])
    begin
      next_s.periodSelect = avs_writedata[`WD_PERIOD_MSB:`WD_PERIOD_LSB];
      next_s.softEnable   = avs_writedata[`WD_SOFT_EN_BIT];
    end

    // status write: one clears the reset flag
    if (writeTaken && avs_address == `WD_STATUS_OFFSET && avs_byteenable[0]
        && avs_writedata[`WD_STAT_RESET_FLAG])
    begin
      next_s.resetFlag = 1'b0;
    end

    // core events on the status flags
    if (clearInstruction)
    begin
      next_s.expiryFlagN = 1'b1;
      next_s.sleepFlagN  = 1'b1;
    end

    // sleep state machine
    case (s.sleepState)
      AWAKE:
      begin
        if (sleepEnter)
        begin
          next_s.sleepState  = ASLEEP;
          next_s.expiryFlagN = 1'b1;
          next_s.sleepFlagN  = 1'b0;
        end
      end
      ASLEEP:
      begin
        if (sleepExit | expire)
        begin
          next_s.sleepState = crystalClock ? OST_HOLD : AWAKE;
        end
      end
      OST_HOLD:
      begin
        if (~startupHoldTimer)
        begin
          next_s.sleepState = AWAKE;
        end
      end
      default:
      begin
        next_s.sleepState = AWAKE;
      end
    endcase

    // expiry: wake while asleep, reset while awake
    if (expire)
    begin
      next_s.expiryFlagN = 1'b0;
      next_s.resetFlag   = 1'b1;
      if (asleep)
      begin
        next_s.wakeReq    = 1'b1;
        next_s.sleepFlagN = 1'b0;
      end
      else
      begin
        next_s.wdReset = 1'b1;
      end
    end

    // synchronous reset; status flags survive all but power-on
    if (rst)
    begin
      next_s.periodSelect = `WD_PERIOD_RESET;
      next_s.softEnable   = `WD_SOFT_EN_RESET;
      next_s.sleepState   = AWAKE;
      next_s.lfSync       = 3'h0;
      next_s.lfLevel      = 1'b0;
      next_s.count        = '0;
      next_s.wdReset      = 1'b0;
      next_s.wakeReq      = 1'b0;
      next_s.ack          = 1'b0;
      next_s.readData     = 32'h0;
      if (powerOnReset)
      begin
        next_s.expiryFlagN = 1'b1;
        next_s.sleepFlagN  = 1'b1;
        next_s.resetFlag   = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    s <= next_s;
  end

  // outputs
  assign avs_waitrequest   = busReq & ~s.ack;
  assign avs_readdata      = s.readData;
  assign watchdogReset     = s.wdReset;
  assign wakeRequest       = s.wakeReq;
  assign expiryFlagN       = s.expiryFlagN;
  assign sleepFlagN        = s.sleepFlagN;
  assign watchdogResetFlag = s.resetFlag;

endmodule // watchdog_timer_control
